// ===== logic/ptc_pkg.sv
// Constants for the paired timer control block
package ptc_pkg;
  localparam logic [3:0] ADDR_EVEN_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ODD_CTRL  = 4'h1;
  localparam logic [3:0] ADDR_EVEN_PER  = 4'h2;
  localparam logic [3:0] ADDR_ODD_PER   = 4'h3;
  localparam logic [3:0] ADDR_EVEN_CNT  = 4'h4;
  localparam logic [3:0] ADDR_ODD_CNT   = 4'h5;
  localparam logic [3:0] ADDR_INT_STAT  = 4'h6;
  localparam logic [3:0] ADDR_INT_MASK  = 4'h7;
  localparam int BIT_RUN   = 15;
  localparam int BIT_HALT  = 13;
  localparam int BIT_GATE  = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_PAIR  = 3;
  localparam int BIT_CSRC  = 1;
  localparam logic [15:0] EVEN_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] ODD_CTRL_MASK  = 16'hA072;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] PER_RESET      = 16'hFFFF;
  localparam logic [7:0]  PS_DIV8_M1     = 8'h07;
  localparam logic [7:0]  PS_DIV64_M1    = 8'h3F;
  localparam logic [7:0]  PS_DIV256_M1   = 8'hFF;
endpackage : ptc_pkg

// ===== logic/ptc_tick.sv
// Clock source, gate and prescaler for one timer
`timescale 1ns/10ps
`default_nettype none
module ptc_tick (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       run_i,
  input  wire logic       gate_en_i,
  input  wire logic [1:0] ps_sel_i,
  input  wire logic       csrc_i,
  input  wire logic       ext_clk_i,
  input  wire logic       gate_i,
  output logic            tick_o
);
  import ptc_pkg::*;
  logic       ext_q;
  logic [7:0] ps_q;
  logic [7:0] ps_d;
  logic [7:0] ps_top;
  logic       src_evt;
  assign src_evt = csrc_i ? (ext_clk_i & ~ext_q)
                          : (~gate_en_i | gate_i);
  assign ps_top = (ps_sel_i == 2'b00) ? 8'h00 :
                  (ps_sel_i == 2'b01) ? PS_DIV8_M1 :
                  (ps_sel_i == 2'b10) ? PS_DIV64_M1 : PS_DIV256_M1;
  assign ps_d = (!run_i) ? 8'h00 :
                (src_evt && ps_q >= ps_top) ? 8'h00 :
                src_evt ? ps_q + 8'h01 : ps_q;
  assign tick_o = run_i && src_evt && (ps_q >= ps_top);
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ext_q <= 1'b0;
      ps_q  <= 8'h00;
    end else begin
      ext_q <= ext_clk_i;
      ps_q  <= ps_d;
    end
  end
  a_ps_bound: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (tick_o && ps_sel_i == 2'b01)
    |=> (!tick_o || ps_sel_i != 2'b01) [*7])
    else $error("prescaler 1:8 ticked early");
endmodule : ptc_tick
`default_nettype wire

// ===== logic/ptc_top.sv
// Paired 16/32-bit timer with control registers and interrupt
// Behaviour
// - Unimplemented control bits read zero and ignore writes.
// - With internal clock, gate enable makes the timer count only while gate is high.
// - Prescale field selects 1:1, 1:8, 1:64 or 1:256.
// - Pair bit joins even and odd timers into one 32-bit timer.
// - Clock source bit selects rising edges of the external pin or the internal clock.
// - Run bit starts and stops the 16-bit or joined 32-bit timer.
// - When paired, odd control is ignored and match flags on the odd flag.
// - Halt-in-idle bit stops the timer while the device is idle.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ptc_top (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        idle_i,
  input  wire logic        even_ext_clk_i,
  input  wire logic        odd_ext_clk_i,
  input  wire logic        even_gate_i,
  input  wire logic        odd_gate_i,
  output logic             irq_o
);
  import ptc_pkg::*;
  logic [15:0] even_ctrl_q;
  logic [15:0] odd_ctrl_q;
  logic [15:0] even_per_q;
  logic [15:0] odd_per_q;
  logic [15:0] even_cnt_q;
  logic [15:0] odd_cnt_q;
  logic [1:0]  stat_q;
  logic [1:0]  mask_q;
  logic [15:0] rdata_d;
  logic        irq_q;
  logic        pair;
  logic        even_run;
  logic        odd_run;
  logic        even_tick;
  logic        odd_tick;
  logic        even_match;
  logic        odd_match;
  logic        match32;
  logic        even_wrap;
  logic        odd_wrap;
  logic        even_evt;
  logic        odd_evt;
  logic [31:0] cnt32;
  logic [31:0] per32;
  logic [31:0] cnt32_d;
  logic [15:0] even_cnt_d;
  logic [15:0] odd_cnt_d;
  logic [1:0]  stat_d;
  logic        wr_ec;
  logic        wr_oc;

  function automatic logic run_ok(input logic [15:0] c, input logic idle);
    return c[BIT_RUN] && !(idle && c[BIT_HALT]);
  endfunction : run_ok

  assign pair     = even_ctrl_q[BIT_PAIR];
  assign even_run = run_ok(even_ctrl_q, idle_i);
  assign odd_run  = !pair && run_ok(odd_ctrl_q, idle_i);

  ptc_tick u_even_tick (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (even_run),
    .gate_en_i (even_ctrl_q[BIT_GATE]),
    .ps_sel_i  (even_ctrl_q[BIT_PS_HI:BIT_PS_LO]),
    .csrc_i    (even_ctrl_q[BIT_CSRC]),
    .ext_clk_i (even_ext_clk_i),
    .gate_i    (even_gate_i),
    .tick_o    (even_tick)
  );
  ptc_tick u_odd_tick (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (odd_run),
    .gate_en_i (odd_ctrl_q[BIT_GATE]),
    .ps_sel_i  (odd_ctrl_q[BIT_PS_HI:BIT_PS_LO]),
    .csrc_i    (odd_ctrl_q[BIT_CSRC]),
    .ext_clk_i (odd_ext_clk_i),
    .gate_i    (odd_gate_i),
    .tick_o    (odd_tick)
  );

  assign cnt32      = {odd_cnt_q, even_cnt_q};
  assign per32      = {odd_per_q, even_per_q};
  assign match32    = (cnt32 == per32);
  assign even_match = (even_cnt_q == even_per_q);
  assign odd_match  = (odd_cnt_q == odd_per_q);
  assign even_wrap  = even_tick && even_match;
  assign odd_wrap   = odd_tick && odd_match;
  // Joined mode raises only the odd flag
  assign even_evt   = !pair && even_wrap;
  assign odd_evt    = pair ? (even_tick && match32) : odd_wrap;
  assign cnt32_d    = match32 ? 32'h0000_0000 : cnt32 + 32'h0000_0001;

  assign wr_ec = wr_i && addr_i == ADDR_EVEN_CNT;
  assign wr_oc = wr_i && addr_i == ADDR_ODD_CNT;
  assign even_cnt_d = wr_ec ? wdata_i :
                      (pair && even_tick) ? cnt32_d[15:0] :
                      even_wrap ? 16'h0000 :
                      even_tick ? even_cnt_q + 16'h0001 : even_cnt_q;
  assign odd_cnt_d  = wr_oc ? wdata_i :
                      (pair && even_tick) ? cnt32_d[31:16] :
                      odd_wrap ? 16'h0000 :
                      odd_tick ? odd_cnt_q + 16'h0001 : odd_cnt_q;

  // Set wins over write-one-to-clear
  assign stat_d = (stat_q & ~((wr_i && addr_i == ADDR_INT_STAT) ?
                              wdata_i[1:0] : 2'b00))
                  | {odd_evt, even_evt};

  assign rdata_d =
    !rd_i                     ? 16'h0000 :
    (addr_i == ADDR_EVEN_CTRL) ? even_ctrl_q :
    (addr_i == ADDR_ODD_CTRL)  ? odd_ctrl_q :
    (addr_i == ADDR_EVEN_PER)  ? even_per_q :
    (addr_i == ADDR_ODD_PER)   ? odd_per_q :
    (addr_i == ADDR_EVEN_CNT)  ? even_cnt_q :
    (addr_i == ADDR_ODD_CNT)   ? odd_cnt_q :
    (addr_i == ADDR_INT_STAT)  ? {14'h0000, stat_q} :
    (addr_i == ADDR_INT_MASK)  ? {14'h0000, mask_q} : 16'h0000;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      even_ctrl_q <= CTRL_RESET;
      odd_ctrl_q  <= CTRL_RESET;
      even_per_q  <= PER_RESET;
      odd_per_q   <= PER_RESET;
      mask_q      <= 2'b00;
    end else if (wr_i) begin
      if (addr_i == ADDR_EVEN_CTRL) begin
        even_ctrl_q <= wdata_i & EVEN_CTRL_MASK;
      end
      if (addr_i == ADDR_ODD_CTRL) begin
        odd_ctrl_q <= wdata_i & ODD_CTRL_MASK;
      end
      if (addr_i == ADDR_EVEN_PER) begin
        even_per_q <= wdata_i;
      end
      if (addr_i == ADDR_ODD_PER) begin
        odd_per_q <= wdata_i;
      end
      if (addr_i == ADDR_INT_MASK) begin
        mask_q <= wdata_i[1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      even_cnt_q <= 16'h0000;
      odd_cnt_q  <= 16'h0000;
      stat_q     <= 2'b00;
      rdata_o    <= 16'h0000;
      irq_q      <= 1'b0;
    end else begin
      even_cnt_q <= even_cnt_d;
      odd_cnt_q  <= odd_cnt_d;
      stat_q     <= stat_d;
      rdata_o    <= rdata_d;
      irq_q      <= |(stat_d & mask_q);
    end
  end
  assign irq_o = irq_q;

  a_ctrl_zero: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (even_ctrl_q & ~EVEN_CTRL_MASK) == 16'h0000)
    else $error("unimplemented control bit set");
  a_odd_zero: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (odd_ctrl_q & ~ODD_CTRL_MASK) == 16'h0000)
    else $error("unimplemented odd control bit set");
  a_ctrl_write: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == ADDR_EVEN_CTRL)
    |=> even_ctrl_q == ($past(wdata_i) & EVEN_CTRL_MASK))
    else $error("control write not masked");
  // Read data stands one cycle after the strobe, zero otherwise
  a_rd_idle: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero between reads");
  a_rd_ctrl: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ($past(rd_i) && $past(addr_i) == ADDR_EVEN_CTRL)
    |-> rdata_o == $past(even_ctrl_q))
    else $error("control read back wrong");
  a_rd_unmap: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ($past(rd_i) && $past(addr_i) > ADDR_INT_MASK)
    |-> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_stop_hold: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (!even_ctrl_q[BIT_RUN] && !wr_i) |=> $stable(even_cnt_q))
    else $error("stopped timer moved");
  a_odd_stop: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !odd_run |-> !odd_tick)
    else $error("stopped odd timer ticked");
  a_pair_run: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (pair && !even_ctrl_q[BIT_RUN]) |-> !even_tick && !odd_tick)
    else $error("stopped joined timer ticked");
  a_idle_halt: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (idle_i && even_ctrl_q[BIT_HALT]) |-> !even_tick)
    else $error("timer ticked in idle");
  a_odd_idle: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (idle_i && odd_ctrl_q[BIT_HALT]) |-> !odd_tick)
    else $error("odd timer ticked in idle");
  a_pair_odd: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    pair |-> !odd_tick && !even_evt)
    else $error("odd timer active while paired");
  a_pair_flag0: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (pair && !stat_q[0]) |=> !stat_q[0])
    else $error("even flag set while paired");
  a_wrap_zero: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (even_wrap && !pair && !wr_i) |=> even_cnt_q == 16'h0000 && stat_q[0])
    else $error("period match wrong");
  a_odd_wrap: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (odd_wrap && !pair && !wr_i) |=> odd_cnt_q == 16'h0000 && stat_q[1])
    else $error("odd period match wrong");
  a_inc_one: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (even_tick && !even_match && !pair && !wr_i)
    |=> even_cnt_q == $past(even_cnt_q) + 16'h0001)
    else $error("count did not increment");
  a_odd_inc: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (odd_tick && !odd_match && !wr_i)
    |=> odd_cnt_q == $past(odd_cnt_q) + 16'h0001)
    else $error("odd count did not increment");
  a_gate_block: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (!even_ctrl_q[BIT_CSRC] && even_ctrl_q[BIT_GATE] && !even_gate_i)
    |-> !even_tick)
    else $error("tick with gate closed");
  a_odd_gate: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (!odd_ctrl_q[BIT_CSRC] && odd_ctrl_q[BIT_GATE] && !odd_gate_i)
    |-> !odd_tick)
    else $error("odd tick with gate closed");
  a_ext_edge: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (even_ctrl_q[BIT_CSRC] && even_tick) |-> even_ext_clk_i)
    else $error("external tick without high pin");
  a_ext_rise: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (even_ctrl_q[BIT_CSRC] && even_tick) |-> !$past(even_ext_clk_i))
    else $error("external tick without rising edge");
  a_odd_ext: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (odd_ctrl_q[BIT_CSRC] && odd_tick) |-> odd_ext_clk_i)
    else $error("odd external tick without high pin");
  a_int_every: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (even_run && !even_ctrl_q[BIT_CSRC] && !even_ctrl_q[BIT_GATE]
     && even_ctrl_q[BIT_PS_HI:BIT_PS_LO] == 2'b00) |-> even_tick)
    else $error("1:1 internal tick missing");
  sequence s_even_tick8;
    even_tick && even_ctrl_q[BIT_PS_HI:BIT_PS_LO] == 2'b01;
  endsequence
  sequence s_even_quiet7;
    (!even_tick || even_ctrl_q[BIT_PS_HI:BIT_PS_LO] != 2'b01) [*7];
  endsequence
  a_even_ps8: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    s_even_tick8 |=> s_even_quiet7)
    else $error("even 1:8 tick too early");
  a_pair_carry: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (pair && even_tick && !match32 && !wr_i)
    |=> cnt32 == $past(cnt32) + 32'h0000_0001)
    else $error("32-bit count wrong");
  sequence s_pair_wrap;
    pair && even_tick && match32 && !wr_i;
  endsequence
  sequence s_pair_zeroed;
    cnt32 == 32'h0000_0000 && stat_q[1];
  endsequence
  a_pair_wrap: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    s_pair_wrap |=> s_pair_zeroed)
    else $error("32-bit period match wrong");
  a_cnt_write: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == ADDR_EVEN_CNT) |=> even_cnt_q == $past(wdata_i))
    else $error("count write lost");
  a_stat_hold: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (stat_q[1] && !(wr_i && addr_i == ADDR_INT_STAT && wdata_i[1]))
    |=> stat_q[1])
    else $error("status flag not sticky");
  a_stat_clear: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == ADDR_INT_STAT && wdata_i[0] && !even_evt)
    |=> !stat_q[0])
    else $error("status flag not cleared");
  a_mask_quiet: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (mask_q == 2'b00) |=> !irq_o)
    else $error("masked interrupt raised");
  a_irq_level: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    irq_o == |($past(stat_d) & $past(mask_q)))
    else $error("interrupt level wrong");
endmodule : ptc_top
`default_nettype wire

// ===== bench/ptc_ext_src.sv
// Model of the external clock source on the even timer pin
`timescale 1ns/10ps
`default_nettype none
module ptc_ext_src (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        en_i,
  output logic             pin_o,
  output logic      [15:0] edges_o
);
  logic [1:0] div_q;
  // Slow square wave while enabled, held low between bursts
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !en_i) begin
      div_q <= 2'h0;
      pin_o <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        pin_o <= ~pin_o;
      end
    end
    if (sys_rst_i) begin
      edges_o <= 16'h0000;
    end else if (en_i && div_q == 2'h3 && !pin_o) begin
      edges_o <= edges_o + 16'h0001;
    end
  end
endmodule : ptc_ext_src
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the paired timer control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ptc_pkg::*;
  logic        clk, rst, wr, rd, idle, eg, xen, irq, pin;
  logic [3:0]  addr;
  logic [15:0] wd, rdat, v, edg, e0;
  logic [31:0] seed;
  int          err_total, total_checks, hi;
  int          dv [4] = '{1, 8, 64, 256};
  ptc_top DUT (.ref_clk_i(clk), .sys_rst_i(rst), .addr_i(addr),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .idle_i(idle),
    .even_ext_clk_i(pin), .odd_ext_clk_i(1'b0), .even_gate_i(eg),
    .odd_gate_i(1'b0), .irq_o(irq));
  ptc_ext_src src (.ref_clk_i(clk), .sys_rst_i(rst), .en_i(xen),
    .pin_o(pin), .edges_o(edg));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask : rd_reg
  task automatic chk(input logic [15:0] lo, input logic [15:0] hv);
    total_checks++;
    if ((v >= lo && v <= hv) !== 1'b1) begin
      $display("ERROR t=%0t got %h want %h..%h", $time, v, lo, hv);
      err_total++;
    end
  endtask : chk
  task automatic run_cnt(input logic [15:0] c, input int n);
    wr_reg(ADDR_EVEN_CNT, 16'h0000);
    wr_reg(ADDR_EVEN_CTRL, c);
    repeat (n) @(posedge clk);
    wr_reg(ADDR_EVEN_CTRL, 16'h0000);
    rd_reg(ADDR_EVEN_CNT);
  endtask : run_cnt
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    end_of_test;
  end
  initial begin
    err_total = 0;
    total_checks = 0;
    seed = 32'h0000_05E5;
    {rst, wr, rd, idle, eg, xen} = 6'h20;
    addr = 4'h0;
    wd = 16'h0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ADDR_EVEN_PER);
    chk(16'hFFFF, 16'hFFFF);
    rd_reg(4'h9);
    chk(16'h0000, 16'h0000);
    repeat (6) begin
      seed = xs(seed);
      wr_reg(ADDR_EVEN_CTRL, seed[15:0] & 16'h7FFF);
      rd_reg(ADDR_EVEN_CTRL);
      chk(seed[15:0] & 16'h207A, seed[15:0] & 16'h207A);
      wr_reg(ADDR_ODD_CTRL, seed[31:16] & 16'h7FFF);
      rd_reg(ADDR_ODD_CTRL);
      chk(seed[31:16] & 16'h2072, seed[31:16] & 16'h2072);
    end
    wr_reg(ADDR_ODD_CTRL, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      run_cnt(16'h8000 | 16'(k << 4), 20 * dv[k]);
      chk(16'd19, 16'd24);
      e0 = v;
      rd_reg(ADDR_EVEN_CNT);
      chk(e0, e0);
    end
    wr_reg(ADDR_EVEN_CNT, 16'h0000);
    wr_reg(ADDR_EVEN_CTRL, 16'h8040);
    hi = 0;
    repeat (200) begin
      seed = xs(seed);
      eg <= seed[3];
      hi += int'(seed[3]);
      @(posedge clk);
    end
    eg <= 1'b0;
    wr_reg(ADDR_EVEN_CTRL, 16'h0000);
    rd_reg(ADDR_EVEN_CNT);
    chk(16'(hi - 2), 16'(hi + 2));
    wr_reg(ADDR_EVEN_CNT, 16'h0000);
    // External source on the timer that has a pin, gate low but ignored
    wr_reg(ADDR_EVEN_CTRL, 16'h8042);
    e0 = edg;
    xen <= 1'b1;
    repeat (100) @(posedge clk);
    xen <= 1'b0;
    repeat (4) @(posedge clk);
    wr_reg(ADDR_EVEN_CTRL, 16'h0000);
    rd_reg(ADDR_EVEN_CNT);
    chk(edg - e0 - 16'h0001, edg - e0);
    idle <= 1'b1;
    run_cnt(16'hA000, 30);
    chk(16'h0000, 16'h0000);
    run_cnt(16'h8000, 30);
    chk(16'd29, 16'd34);
    idle <= 1'b0;
    wr_reg(ADDR_EVEN_PER, 16'h0004);
    run_cnt(16'h8000, 20);
    chk(16'h0000, 16'h0004);
    rd_reg(ADDR_INT_STAT);
    chk(16'h0001, 16'h0001);
    v = {15'h0000, irq};
    chk(16'h0000, 16'h0000);
    wr_reg(ADDR_INT_MASK, 16'h0003);
    repeat (2) @(posedge clk);
    #1 v = {15'h0000, irq};
    chk(16'h0001, 16'h0001);
    wr_reg(ADDR_INT_STAT, 16'h0001);
    rd_reg(ADDR_INT_STAT);
    chk(16'h0000, 16'h0000);
    v = {15'h0000, irq};
    chk(16'h0000, 16'h0000);
    wr_reg(ADDR_EVEN_PER, 16'h0002);
    wr_reg(ADDR_ODD_PER, 16'h0001);
    wr_reg(ADDR_ODD_CNT, 16'h0000);
    wr_reg(ADDR_ODD_CTRL, 16'h8030);
    wr_reg(ADDR_EVEN_CNT, 16'hFFFE);
    wr_reg(ADDR_EVEN_CTRL, 16'h8008);
    repeat (10) @(posedge clk);
    wr_reg(ADDR_EVEN_CTRL, 16'h0008);
    rd_reg(ADDR_INT_STAT);
    chk(16'h0002, 16'h0002);
    wr_reg(ADDR_ODD_CTRL, 16'h0000);
    wr_reg(ADDR_EVEN_CTRL, 16'h0000);
    wr_reg(ADDR_INT_STAT, 16'h0003);
    wr_reg(ADDR_ODD_PER, 16'h0003);
    wr_reg(ADDR_ODD_CNT, 16'h0000);
    wr_reg(ADDR_ODD_CTRL, 16'h8000);
    repeat (10) @(posedge clk);
    wr_reg(ADDR_ODD_CTRL, 16'h0000);
    rd_reg(ADDR_ODD_CNT);
    chk(16'h0000, 16'h0003);
    rd_reg(ADDR_INT_STAT);
    chk(16'h0002, 16'h0002);
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
